/* File: shared/dtc_defs.vh */
// Purpose: offsets, field positions, reset values and timing counts of the dual timer/counter
// Assumes: classic wishbone with 8-bit data; offsets are byte addresses
// Notes: definitions only
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

`define DTC_ADDR_W 8
// register offsets
`define DTC_OFS_CTRL 8'h88
`define DTC_OFS_MODE 8'h89
`define DTC_OFS_A_LO 8'h8a
`define DTC_OFS_B_LO 8'h8b
`define DTC_OFS_A_HI 8'h8c
`define DTC_OFS_B_HI 8'h8d
`define DTC_OFS_CKMODE 8'h8e
`define DTC_OFS_PINSET 8'hb5
`define DTC_OFS_EVENT 8'hb6
// timer control fields
`define DTC_CTRL_B_OVF 7
`define DTC_CTRL_B_RUN 6
`define DTC_CTRL_A_OVF 5
`define DTC_CTRL_A_RUN 4
// timer mode fields, timer b upper nibble, timer a lower nibble
`define DTC_MODE_B_SHIFT 4
`define DTC_MODE_GATE 3
`define DTC_MODE_CT 2
`define DTC_MODE_HI 1
`define DTC_MODE_LO 0
// clock mode fields
`define DTC_CK_B_SEL 4
`define DTC_CK_A_SEL 3
`define DTC_CK_MASK 8'h5a
// pin setting fields
`define DTC_PS_B_OE 3
`define DTC_PS_A_OE 2
`define DTC_PS_MASK 8'h8d
// event register: write 1 to bit 0/1 = service entry of timer a/b
`define DTC_EV_A_ACK 0
`define DTC_EV_B_ACK 1
// reset values
`define DTC_RST_8 8'h00
// counting modes
`define DTC_M13 2'b00
`define DTC_M16 2'b01
`define DTC_M8R 2'b10
`define DTC_MSPLIT 2'b11
// prescale for the legacy timer rate
`define DTC_PRESCALE 12
`define DTC_PRE_W 4

`endif

/* File: design/dtc_sync.v */
// Purpose: two-flop synchroniser with falling-edge detection for one pin
// Assumes: pin is asynchronous to clk_i
// Notes: edge detect reads only the second and third flops
`timescale 1ns/100ps
`default_nettype none
module dtc_sync (
	input wire clk_i,
	input wire rst_i,
	input wire pin_i,
	output wire level_o,
	output wire fall_o
);
	reg meta_ff;
	reg sync_ff;
	reg last_ff;

	// first flop only feeds the second; idle high avoids a false edge at reset
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			last_ff <= 1'b1;
		end else begin
			meta_ff <= pin_i;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign level_o = sync_ff;
	assign fall_o = last_ff & ~sync_ff;
endmodule // dtc_sync
`default_nettype wire

/* File: design/dtc_timers.v */
// Purpose: two legacy timer/counters with 13, 16, 8-bit reload and split modes
// Assumes: classic wishbone slave, 8-bit data, single 10 MHz clock
// Notes: service entry of an overflow flag is signalled by isr_a_i/isr_b_i pulses
`timescale 1ns/100ps
`default_nettype none
`include "dtc_defs.vh"
module dtc_timers (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [`DTC_ADDR_W-1:0] adr_i,
	input wire [7:0] dat_i,
	input wire sel_i,
	output reg [7:0] dat_o,
	output reg ack_o,
	input wire isr_a_i,
	input wire isr_b_i,
	input wire timer_a_count_pin_i,
	input wire timer_b_count_pin_i,
	input wire timer_a_gate_pin_i,
	input wire timer_b_gate_pin_i,
	output wire timer_a_count_pin_o,
	output wire timer_a_count_pin_oe_n_o,
	output wire timer_b_count_pin_o,
	output wire timer_b_count_pin_oe_n_o,
	output wire timer_a_overflow_flag_o,
	output wire timer_b_overflow_flag_o,
	output reg baud_tick_o
);
	reg [7:0] ctrl_ff;
	reg [7:0] mode_ff;
	reg [7:0] ckmode_ff;
	reg [7:0] pinset_ff;
	reg [7:0] a_lo_ff, a_hi_ff, b_lo_ff, b_hi_ff;
	reg [`DTC_PRE_W-1:0] pre_ff;
	reg a_out_ff, b_out_ff;
	reg [7:0] nxt_a_lo, nxt_a_hi, nxt_b_lo, nxt_b_hi;
	reg a_ovf, b_ovf, ah_ovf;
	reg [8:0] sum_lo;
	reg [8:0] sum_hi;
	wire a_pin_fall, b_pin_fall;
	wire a_gate_lvl, b_gate_lvl;
	wire pre_tick;
	wire [1:0] a_mode, b_mode;
	wire a_tick, b_tick, ah_tick, a_en, b_en;
	wire wr, rd_ok;

	// pins pass two flops before any logic reads them
	dtc_sync u_sync_ac (.clk_i(clk_i), .rst_i(rst_i), .pin_i(timer_a_count_pin_i),
		.level_o(), .fall_o(a_pin_fall));
	dtc_sync u_sync_bc (.clk_i(clk_i), .rst_i(rst_i), .pin_i(timer_b_count_pin_i),
		.level_o(), .fall_o(b_pin_fall));
	dtc_sync u_sync_ag (.clk_i(clk_i), .rst_i(rst_i), .pin_i(timer_a_gate_pin_i),
		.level_o(a_gate_lvl), .fall_o());
	dtc_sync u_sync_bg (.clk_i(clk_i), .rst_i(rst_i), .pin_i(timer_b_gate_pin_i),
		.level_o(b_gate_lvl), .fall_o());
	// count pins are read only for their falling edges, never as levels
	// gate pins are read as levels, so their edge outputs stay open

	// shared divide-by-12 enable, free running so both timers share phase
	// limitation: a new clock select is not re-phased, the first slow tick may come early
	always @(posedge clk_i) begin
		if (rst_i) begin
			pre_ff <= {`DTC_PRE_W{1'b0}};
		end else if (pre_ff == (`DTC_PRESCALE - 1)) begin
			pre_ff <= {`DTC_PRE_W{1'b0}};
		end else begin
			pre_ff <= pre_ff + 1'b1;
		end
	end
	assign pre_tick = (pre_ff == (`DTC_PRESCALE - 1));

	assign a_mode = mode_ff[`DTC_MODE_HI:`DTC_MODE_LO];
	assign b_mode = mode_ff[`DTC_MODE_B_SHIFT+1:`DTC_MODE_B_SHIFT];

	// count source per timer: pin edge, undivided clock or /12 enable
	// counter select wins over clock select, the pin edge replaces the clock entirely
	assign a_tick = mode_ff[`DTC_MODE_CT] ? a_pin_fall :
		(ckmode_ff[`DTC_CK_A_SEL] ? 1'b1 : pre_tick);
	assign b_tick = mode_ff[`DTC_MODE_B_SHIFT+`DTC_MODE_CT] ? b_pin_fall :
		(ckmode_ff[`DTC_CK_B_SEL] ? 1'b1 : pre_tick);
	// split high byte is always a clock-cycle counter under timer a's clock select
	assign ah_tick = ckmode_ff[`DTC_CK_A_SEL] ? 1'b1 : pre_tick;

	// run and gate qualification
	assign a_en = ctrl_ff[`DTC_CTRL_A_RUN] & (~mode_ff[`DTC_MODE_GATE] | a_gate_lvl);
	// in split mode timer b loses its run bit and runs unless in its own mode 3
	assign b_en = ((a_mode == `DTC_MSPLIT) | ctrl_ff[`DTC_CTRL_B_RUN]) &
		(~mode_ff[`DTC_MODE_B_SHIFT+`DTC_MODE_GATE] | b_gate_lvl) &
		(b_mode != `DTC_MSPLIT);

	// next counter values and overflow events
	// a software write to a counter byte overrides these values in the register process
	always @* begin
		nxt_a_lo = a_lo_ff;
		nxt_a_hi = a_hi_ff;
		nxt_b_lo = b_lo_ff;
		nxt_b_hi = b_hi_ff;
		a_ovf = 1'b0;
		b_ovf = 1'b0;
		ah_ovf = 1'b0;
		sum_lo = 9'h000;
		sum_hi = 9'h000;
		if (a_en && a_tick) begin
			case (a_mode)
			`DTC_M13: begin
				// upper three low-byte bits are left alone
				sum_lo = {4'h0, a_lo_ff[4:0]} + 9'h001;
				nxt_a_lo = {a_lo_ff[7:5], sum_lo[4:0]};
				if (sum_lo[5]) begin
					sum_hi = {1'b0, a_hi_ff} + 9'h001;
					nxt_a_hi = sum_hi[7:0];
					a_ovf = sum_hi[8];
				end
			end
			`DTC_M16: begin
				sum_lo = {1'b0, a_lo_ff} + 9'h001;
				nxt_a_lo = sum_lo[7:0];
				if (sum_lo[8]) begin
					sum_hi = {1'b0, a_hi_ff} + 9'h001;
					nxt_a_hi = sum_hi[7:0];
					a_ovf = sum_hi[8];
				end
			end
			`DTC_M8R: begin
				sum_lo = {1'b0, a_lo_ff} + 9'h001;
				nxt_a_lo = sum_lo[8] ? a_hi_ff : sum_lo[7:0];
				a_ovf = sum_lo[8];
			end
			`DTC_MSPLIT: begin
				sum_lo = {1'b0, a_lo_ff} + 9'h001;
				nxt_a_lo = sum_lo[7:0];
				a_ovf = sum_lo[8];
			end
			default: begin
				nxt_a_lo = a_lo_ff;
			end
			endcase
		end
		// split high byte: started by timer b run bit
		// it ignores gate and counter select, it only ever counts clock-rate enables
		if ((a_mode == `DTC_MSPLIT) && ctrl_ff[`DTC_CTRL_B_RUN] && ah_tick) begin
			nxt_a_hi = a_hi_ff + 8'h01;
			ah_ovf = (a_hi_ff == 8'hff);
		end
		// timer b: same modes without a split; its own mode 3 holds the count
		if (b_en && b_tick) begin
			case (b_mode)
			`DTC_M13: begin
				// carry out of the five low bits only, upper three bits kept
				nxt_b_lo = {b_lo_ff[7:5], b_lo_ff[4:0] + 5'h01};
				if (b_lo_ff[4:0] == 5'h1f) begin
					nxt_b_hi = b_hi_ff + 8'h01;
					b_ovf = (b_hi_ff == 8'hff);
				end
			end
			`DTC_M16: begin
				nxt_b_lo = b_lo_ff + 8'h01;
				if (b_lo_ff == 8'hff) begin
					nxt_b_hi = b_hi_ff + 8'h01;
					b_ovf = (b_hi_ff == 8'hff);
				end
			end
			`DTC_M8R: begin
				nxt_b_lo = (b_lo_ff == 8'hff) ? b_hi_ff : b_lo_ff + 8'h01;
				b_ovf = (b_lo_ff == 8'hff);
			end
			default: begin
				nxt_b_lo = b_lo_ff;
			end
			endcase
		end
	end

	// bus decode: one wait state, ack is registered one cycle after the strobe
	// ~ack_o keeps a strobe that is still held from being taken a second time
	assign wr = cyc_i & stb_i & we_i & sel_i & ~ack_o;
	assign rd_ok = cyc_i & stb_i & ~ack_o;

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= `DTC_RST_8;
		end else begin
			ack_o <= rd_ok;
			case (adr_i)
			`DTC_OFS_CTRL: dat_o <= ctrl_ff;
			`DTC_OFS_MODE: dat_o <= mode_ff;
			`DTC_OFS_A_LO: dat_o <= a_lo_ff;
			`DTC_OFS_A_HI: dat_o <= a_hi_ff;
			`DTC_OFS_B_LO: dat_o <= b_lo_ff;
			`DTC_OFS_B_HI: dat_o <= b_hi_ff;
			`DTC_OFS_CKMODE: dat_o <= ckmode_ff;
			`DTC_OFS_PINSET: dat_o <= pinset_ff;
			default: dat_o <= `DTC_RST_8; // unmapped reads zero, still acked
			endcase
		end
	end

	// registers; a software write in the same cycle as a count wins over the count
	// the event offset has no storage, it only strobes the flag clears below
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= `DTC_RST_8;
			mode_ff <= `DTC_RST_8;
			ckmode_ff <= `DTC_RST_8;
			pinset_ff <= `DTC_RST_8;
			a_lo_ff <= `DTC_RST_8;
			a_hi_ff <= `DTC_RST_8;
			b_lo_ff <= `DTC_RST_8;
			b_hi_ff <= `DTC_RST_8;
		end else begin
			a_lo_ff <= (wr && adr_i == `DTC_OFS_A_LO) ? dat_i : nxt_a_lo;
			a_hi_ff <= (wr && adr_i == `DTC_OFS_A_HI) ? dat_i : nxt_a_hi;
			b_lo_ff <= (wr && adr_i == `DTC_OFS_B_LO) ? dat_i : nxt_b_lo;
			b_hi_ff <= (wr && adr_i == `DTC_OFS_B_HI) ? dat_i : nxt_b_hi;
			if (wr && adr_i == `DTC_OFS_MODE) begin
				mode_ff <= dat_i;
			end
			if (wr && adr_i == `DTC_OFS_CKMODE) begin
				ckmode_ff <= dat_i & `DTC_CK_MASK;
			end
			if (wr && adr_i == `DTC_OFS_PINSET) begin
				pinset_ff <= dat_i & `DTC_PS_MASK;
			end
			// run bits and low nibble are plain software bits
			if (wr && adr_i == `DTC_OFS_CTRL) begin
				ctrl_ff[`DTC_CTRL_B_RUN] <= dat_i[`DTC_CTRL_B_RUN];
				ctrl_ff[`DTC_CTRL_A_RUN] <= dat_i[`DTC_CTRL_A_RUN];
				ctrl_ff[3:0] <= dat_i[3:0];
			end
			// overflow flags: set beats software clear and service clear
			if (a_ovf) begin
				ctrl_ff[`DTC_CTRL_A_OVF] <= 1'b1;
			end else if (wr && adr_i == `DTC_OFS_CTRL) begin
				ctrl_ff[`DTC_CTRL_A_OVF] <= dat_i[`DTC_CTRL_A_OVF];
			end else if (isr_a_i || (wr && adr_i == `DTC_OFS_EVENT && dat_i[`DTC_EV_A_ACK])) begin
				ctrl_ff[`DTC_CTRL_A_OVF] <= 1'b0;
			end
			// in split mode the b flag belongs to the a high byte only
			if ((a_mode == `DTC_MSPLIT) ? ah_ovf : b_ovf) begin
				ctrl_ff[`DTC_CTRL_B_OVF] <= 1'b1;
			end else if (wr && adr_i == `DTC_OFS_CTRL) begin
				ctrl_ff[`DTC_CTRL_B_OVF] <= dat_i[`DTC_CTRL_B_OVF];
			end else if (isr_b_i || (wr && adr_i == `DTC_OFS_EVENT && dat_i[`DTC_EV_B_ACK])) begin
				ctrl_ff[`DTC_CTRL_B_OVF] <= 1'b0;
			end
		end
	end

	// output toggles and baud tick; baud tick comes from timer b only
	// toggles run whether or not the pin is enabled, so enabling shows the current phase
	always @(posedge clk_i) begin
		if (rst_i) begin
			a_out_ff <= 1'b0;
			b_out_ff <= 1'b0;
			baud_tick_o <= 1'b0;
		end else begin
			if (a_ovf) begin
				a_out_ff <= ~a_out_ff;
			end
			if (b_ovf) begin
				b_out_ff <= ~b_out_ff;
			end
			baud_tick_o <= b_ovf;
		end
	end

	// pin drive; enable is active low. pin output meant for timer mode only
	// the pad ignores the toggle register until its enable is set
	assign timer_a_count_pin_o = a_out_ff;
	assign timer_b_count_pin_o = b_out_ff;
	assign timer_a_count_pin_oe_n_o = ~pinset_ff[`DTC_PS_A_OE];
	assign timer_b_count_pin_oe_n_o = ~pinset_ff[`DTC_PS_B_OE];
	assign timer_a_overflow_flag_o = ctrl_ff[`DTC_CTRL_A_OVF];
	assign timer_b_overflow_flag_o = ctrl_ff[`DTC_CTRL_B_OVF];
endmodule // dtc_timers
`default_nettype wire

/* File: test/dtcm_props.sv */
// Purpose: port checks of the dual timer/counter
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the design below
`timescale 1ns/100ps
`default_nettype none
module dtcm_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic sel_i,
	input wire logic [7:0] adr_i,
	input wire logic [7:0] dat_i,
	input wire logic [7:0] dat_o,
	input wire logic ack_o,
	input wire logic isr_a_i,
	input wire logic timer_a_count_pin_o,
	input wire logic timer_a_count_pin_oe_n_o,
	input wire logic timer_a_overflow_flag_o
);
default clocking @(posedge clk_i);
endclocking
default disable iff (rst_i);
// request not yet answered
wire logic req = cyc_i & stb_i & ~ack_o;
// writes to pin setting and to the control flag
sequence oe_wr;
	req && we_i && sel_i && adr_i == 8'hb5;
endsequence
sequence flag_wr;
	req && we_i && sel_i && adr_i == 8'h88 && dat_i[5];
endsequence
ack_next_a: assert property (req |=> ack_o)
	else $error("ack late");
ack_pulse_a: assert property (ack_o |=> !ack_o)
	else $error("ack too long");
unmapped_zero_a: assert property (req && !we_i && adr_i == 8'h00 |=> dat_o == 8'h00)
	else $error("unmapped read not zero");
oe_write_a: assert property (oe_wr |=> timer_a_count_pin_oe_n_o == !$past(dat_i[2]))
	else $error("enable not written");
soft_set_a: assert property (flag_wr |=> timer_a_overflow_flag_o)
	else $error("flag not set");
isr_clear_a: assert property (isr_a_i |=> !timer_a_overflow_flag_o || $changed(timer_a_count_pin_o))
	else $error("flag not cleared");
flag_toggle_a: assert property ($changed(timer_a_count_pin_o) |-> timer_a_overflow_flag_o)
	else $error("toggle without flag");
reset_idle_a: assert property ($fell(rst_i) |-> !ack_o && timer_a_count_pin_oe_n_o && !timer_a_overflow_flag_o)
	else $error("bad reset state");
endmodule // dtcm_props
bind dtc_timers dtcm_props dtcm_props_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i, .dat_i,
	.dat_o, .ack_o, .isr_a_i, .timer_a_count_pin_o, .timer_a_count_pin_oe_n_o, .timer_a_overflow_flag_o);
`default_nettype wire

/* File: test/dtcm_pins.sv */
// Purpose: far-side model of the count pins
// Assumes: one request gives one falling edge
// Notes: pads idle high by pull-up
`timescale 1ns/100ps
`default_nettype none
module dtcm_pins (
	input wire logic clk_i,
	input wire logic fall_b_i,
	input wire logic a_o_i,
	input wire logic a_oe_n_i,
	input wire logic b_o_i,
	input wire logic b_oe_n_i,
	output logic a_pin_o,
	output logic b_pin_o
);
// low phase; four clocks outlast the synchroniser
logic [2:0] low_ff = 3'h0;
always @(posedge clk_i) begin
	if (fall_b_i)
		low_ff <= 3'h4;
	else if (low_ff != 3'h0)
		low_ff <= low_ff - 3'h1;
end
// the design wins while it drives the pad
assign a_pin_o = a_oe_n_i ? 1'b1 : a_o_i;
assign b_pin_o = b_oe_n_i ? (low_ff == 3'h0) : b_o_i;
endmodule // dtcm_pins
`default_nettype wire

/* File: test/dual_timer_counter_modes_bench.sv */
// Purpose: self-checking bench of the dual timer/counter
// Assumes: 10 MHz clock, wishbone master tasks
// Notes: counts allow a couple of clocks of bus latency
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter_modes_bench;
logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, sel = 0, isa = 0, isb = 0, ga = 0, gb = 1, fl = 0;
logic ao, aoe, bo, boe, fa, fb, ack, pa, pb, baud;
logic [7:0] adr = 8'h00, dw = 8'h00, dat, q;
int bad_count = 0, comparisons = 0, cycles = 0;
// 100 ns period
always #50 clk = ~clk;
dtc_timers dtc_timers_i (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
	.dat_i(dw), .sel_i(sel), .dat_o(dat), .ack_o(ack), .isr_a_i(isa), .isr_b_i(isb),
	.timer_a_count_pin_i(pa), .timer_b_count_pin_i(pb), .timer_a_gate_pin_i(ga), .timer_b_gate_pin_i(gb),
	.timer_a_count_pin_o(ao), .timer_a_count_pin_oe_n_o(aoe), .timer_b_count_pin_o(bo),
	.timer_b_count_pin_oe_n_o(boe), .timer_a_overflow_flag_o(fa), .timer_b_overflow_flag_o(fb),
	.baud_tick_o(baud));
dtcm_pins dtcm_pins_i (.clk_i(clk), .fall_b_i(fl), .a_o_i(ao), .a_oe_n_i(aoe), .b_o_i(bo), .b_oe_n_i(boe),
	.a_pin_o(pa), .b_pin_o(pb));
task end_sim;
	$display("mismatches %0d comparisons %0d", bad_count, comparisons);
	if (bad_count == 0 && comparisons > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
	comparisons++;
	if (s !== e) begin
		bad_count++;
		$display("wrong value %s expected %h seen %h", nm, e, s);
	end
endtask
// one classic cycle; held until ack is sampled
task wb(input logic [7:0] a, input logic [7:0] d, input logic w);
	cyc <= 1;
	stb <= 1;
	sel <= 1;
	we <= w;
	adr <= a;
	dw <= d;
	@(posedge clk);
	// no wait limit here: only the hang guard ends a missing answer
	while (ack !== 1'b1)
		@(posedge clk);
	q = dat;
	cyc <= 0;
	stb <= 0;
	@(posedge clk);
endtask
task wr(input logic [7:0] a, input logic [7:0] d);
	wb(a, d, 1'b1);
endtask
task rd(input logic [7:0] a);
	wb(a, 8'h00, 1'b0);
endtask
task wfl(input logic b, input int lim);
	int n;
	n = 0;
	while ((b ? fb : fa) !== 1'b1 && n < lim) begin
		@(posedge clk);
		n++;
	end
	chk("overflow flag", 8'h01, {7'h0, b ? fb : fa});
endtask
task t_regs;
	logic [7:0] ofs [9] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'hb5, 8'h00};
	foreach (ofs[i]) begin
		rd(ofs[i]);
		chk("reset value", 8'h00, q);
	end
	wr(8'h8e, 8'hff);
	rd(8'h8e);
	chk("clock mode", 8'h5a, q);
	wr(8'hb5, 8'hff);
	chk("a enable", 8'h00, {7'h0, aoe});
	rd(8'hb5);
	chk("pin setting", 8'h8d, q);
	wr(8'hb5, 8'h00);
	wr(8'h8e, 8'h00);
	wr(8'h88, 8'h20);
	chk("soft flag", 8'h01, {7'h0, fa});
	wr(8'h88, 8'h00);
endtask
task t_mode1;
	logic t;
	t = ao;
	wr(8'h89, 8'h01);
	wr(8'h8e, 8'h08);
	wr(8'h8a, 8'hfe);
	wr(8'h8c, 8'hff);
	wr(8'h88, 8'h10);
	wfl(1'b0, 20);
	chk("a toggle", {7'h0, ~t}, {7'h0, ao});
	isa <= 1;
	@(posedge clk);
	isa <= 0;
	@(posedge clk);
	chk("isr clear", 8'h00, {7'h0, fa});
	wr(8'h88, 8'h00);
endtask
// low byte 3f overflows only if its top bits are ignored
task t_mode0;
	wr(8'h89, 8'h00);
	wr(8'h8a, 8'h3f);
	wr(8'h8c, 8'hff);
	wr(8'h88, 8'h10);
	wfl(1'b0, 8);
	wr(8'h88, 8'h00);
	rd(8'h8c);
	chk("a high", 8'h00, q);
endtask
task t_mode2;
	wr(8'h89, 8'h02);
	wr(8'h8c, 8'hf0);
	wr(8'h8a, 8'hfe);
	wr(8'h88, 8'h10);
	wfl(1'b0, 8);
	wr(8'h88, 8'h00);
	rd(8'h8c);
	chk("reload value", 8'hf0, q);
	rd(8'h8a);
	chk("reloaded low", 8'h01, {7'h0, q >= 8'hf0});
endtask
task t_rate(input logic [7:0] ck, input logic [7:0] e);
	logic [7:0] p;
	wr(8'h89, 8'h01);
	wr(8'h8e, ck);
	wr(8'h8a, 8'h00);
	wr(8'h88, 8'h10);
	repeat (120) @(posedge clk);
	wr(8'h88, 8'h00);
	rd(8'h8a);
	chk("count rate", 8'h01, {7'h0, q >= e - 8'd2 && q <= e + 8'd2});
	p = q;
	repeat (30) @(posedge clk);
	rd(8'h8a);
	chk("held count", p, q);
endtask
task t_gate;
	wr(8'h89, 8'h09);
	wr(8'h8a, 8'h00);
	wr(8'h88, 8'h10);
	repeat (40) @(posedge clk);
	rd(8'h8a);
	chk("gated low", 8'h00, q);
	ga <= 1;
	repeat (40) @(posedge clk);
	rd(8'h8a);
	chk("gate open", 8'h01, {7'h0, q > 8'd35});
	ga <= 0;
	wr(8'h88, 8'h00);
endtask
task t_pin;
	wr(8'h89, 8'h50);
	wr(8'h8b, 8'h00);
	wr(8'h88, 8'h40);
	repeat (3) begin
		fl <= 1;
		@(posedge clk);
		fl <= 0;
		repeat (12) @(posedge clk);
	end
	rd(8'h8b);
	chk("pin edges", 8'h03, q);
	wr(8'h88, 8'h00);
endtask
// timer b: reload mode for flag, baud tick, pin toggle, service clear; 16-bit mode for gate pin
task t_bside;
	logic t;
	logic [7:0] p;
	t = bo;
	wr(8'h89, 8'h20);
	wr(8'h8e, 8'h18);
	wr(8'h8d, 8'hf0);
	wr(8'h8b, 8'hf0);
	wr(8'hb5, 8'h08);
	chk("b enable", 8'h00, {7'h0, boe});
	wr(8'h88, 8'h40);
	wfl(1'b1, 40);
	chk("baud tick", 8'h01, {7'h0, baud});
	chk("b toggle", {7'h0, ~t}, {7'h0, bo});
	isb <= 1;
	@(posedge clk);
	isb <= 0;
	@(posedge clk);
	chk("b isr clear", 8'h00, {7'h0, fb});
	gb <= 0;
	wr(8'h89, 8'h90);
	rd(8'h8b);
	p = q;
	repeat (20) @(posedge clk);
	rd(8'h8b);
	chk("b gated", p, q);
	gb <= 1;
	repeat (20) @(posedge clk);
	rd(8'h8b);
	chk("b gate open", 8'h01, {7'h0, q != p});
	wr(8'h88, 8'h00);
	wr(8'hb5, 8'h00);
endtask
task t_split;
	logic [7:0] p;
	wr(8'h89, 8'h13);
	wr(8'h8c, 8'hfe);
	wr(8'h88, 8'h40);
	wfl(1'b1, 12);
	wr(8'h89, 8'h33);
	rd(8'h8b);
	p = q;
	repeat (40) @(posedge clk);
	rd(8'h8b);
	chk("halted b", p, q);
endtask
// hang guard, far above the run length
always @(posedge clk) begin
	cycles++;
	if (cycles == 5000) begin
		bad_count++;
		end_sim;
	end
end
initial begin
	repeat (20) @(posedge clk);
	rst <= 0;
	@(posedge clk);
	t_regs;
	t_mode1;
	t_mode0;
	t_mode2;
	t_rate(8'h00, 8'd10);
	t_rate(8'h08, 8'd123);
	t_gate;
	t_pin;
	t_bside;
	t_split;
	end_sim;
end
endmodule // dual_timer_counter_modes_bench
`default_nettype wire
